// ### logic/stsr_regs.sv
// Purpose: Supply fault and thermal event bits with a global status byte.
// Assumes: Serial interface decodes offsets and gives a one-cycle read.
// Notes: Read data is registered and valid the cycle after rd_en.
`timescale 1ns/10ps
module stsr_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data_q,
  input wire logic [15:0] supply_sample,
  input wire logic [7:0] temp_sample,
  input wire logic [7:0] over_temp_th,
  input wire logic [7:0] safe_temp_th,
  input wire logic tsd_enable,
  input wire logic ports_powered,
  input wire logic [4:0] addr_pins,
  input wire logic auto_pin,
  output logic ports_hold_off_q,
  output logic thermal_shutdown_q
);
  import stsr_pkg::*;

  // ********************************************************************
  // Strap capture, after reset release
  // ********************************************************************
  logic [4:0] addr_s1_q, addr_s2_q, addr_s3_q;
  logic auto_s1_q, auto_s2_q, auto_s3_q;
  logic strap_done_q;
  logic [7:0] global_status_q;

  always_ff @(posedge clk) begin
    addr_s1_q <= addr_pins;
    addr_s2_q <= addr_s1_q;
    addr_s3_q <= addr_s2_q;
    auto_s1_q <= auto_pin;
    auto_s2_q <= auto_s1_q;
    auto_s3_q <= auto_s2_q;
  end

  // Capture waits until the synchroniser has refilled after reset.
  logic [1:0] strap_wait_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_wait_q <= 2'h0;
      strap_done_q <= 1'b0;
      global_status_q <= GLOBAL_STATUS_RST;
    end else if (!strap_done_q) begin
      if (strap_wait_q != 2'h3) begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end else if (addr_s2_q == addr_s3_q && auto_s2_q == auto_s3_q) begin
        strap_done_q <= 1'b1;
        global_status_q <= 8'h00;
        global_status_q[ADDR_FIELD_LSB +: 5] <= addr_s3_q;
        global_status_q[AUTO_BIT] <= auto_s3_q;
      end
    end
  end

  // ********************************************************************
  // Supply hysteresis and fault event
  // ********************************************************************
  logic supply_bad_q;
  logic supply_bad_d;
  always_comb begin
    supply_bad_d = supply_bad_q;
    if (supply_bad_q && supply_sample > SUPPLY_RISE_CNT) begin
      supply_bad_d = 1'b0;
    end else if (!supply_bad_q && supply_sample < SUPPLY_FALL_CNT) begin
      supply_bad_d = 1'b1;
    end
  end

  // Starts bad so ports stay off until the supply first rises past 44 V.
  always_ff @(posedge clk) begin
    if (rst) begin
      supply_bad_q <= 1'b1;
      ports_hold_off_q <= 1'b1;
    end else begin
      supply_bad_q <= supply_bad_d;
      ports_hold_off_q <= supply_bad_d;
    end
  end

  logic hv_rise;
  assign hv_rise = supply_bad_d && !supply_bad_q;

  // ********************************************************************
  // Thermal shutdown
  // ********************************************************************
  logic [7:0] temp_limit;
  logic tsd_rise;
  assign temp_limit = tsd_enable ? over_temp_th : safe_temp_th;
  assign tsd_rise = ports_powered && (temp_sample > temp_limit) &&
                    !thermal_shutdown_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      thermal_shutdown_q <= 1'b0;
    end else if (tsd_rise) begin
      thermal_shutdown_q <= 1'b1;
    end else if (temp_sample <= temp_limit) begin
      thermal_shutdown_q <= 1'b0;
    end
  end

  // ********************************************************************
  // Clear-on-read event bits
  // ********************************************************************
  logic hv_fault_event_q, tsd_event_q;
  logic cor_read;
  assign cor_read = rd_en && rd_addr == ADDR_EVENT_COR;

  // Set wins over the read-clear so a coincident event is kept.
  always_ff @(posedge clk) begin
    if (rst) begin
      hv_fault_event_q <= 1'b0;
    end else if (hv_rise) begin
      hv_fault_event_q <= 1'b1;
    end else if (cor_read) begin
      hv_fault_event_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tsd_event_q <= 1'b0;
    end else if (tsd_rise) begin
      tsd_event_q <= 1'b1;
    end else if (cor_read) begin
      tsd_event_q <= 1'b0;
    end
  end

  // ********************************************************************
  // Supply word latch
  // ********************************************************************
  logic [7:0] high_hold_q;
  logic high_frozen_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      high_hold_q <= 8'h00;
      high_frozen_q <= 1'b0;
    end else if (rd_en && rd_addr == ADDR_SUPPLY_LOW) begin
      high_hold_q <= supply_sample[15:8];
      high_frozen_q <= 1'b1;
    end else if (rd_en && rd_addr == ADDR_SUPPLY_HIGH) begin
      high_frozen_q <= 1'b0;
    end
  end

  // ********************************************************************
  // Read mux
  // ********************************************************************
  logic [7:0] event_byte;
  always_comb begin
    event_byte = EVENT_RST;
    event_byte[HV_FAULT_BIT] = hv_fault_event_q;
    event_byte[TSD_BIT] = tsd_event_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_q <= 8'h00;
    end else if (rd_en) begin
      unique case (rd_addr)
        ADDR_EVENT_COR: rd_data_q <= event_byte;
        ADDR_GLOBAL_STATUS: rd_data_q <= global_status_q;
        ADDR_DIE_TEMP: rd_data_q <= temp_sample;
        ADDR_SUPPLY_LOW: rd_data_q <= supply_sample[7:0];
        ADDR_SUPPLY_HIGH: rd_data_q <= high_frozen_q ? high_hold_q :
                                        supply_sample[15:8];
        default: rd_data_q <= 8'h00;
      endcase
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  sequence s_low_read;
    rd_en && rd_addr == ADDR_SUPPLY_LOW;
  endsequence

  sequence s_high_read;
    rd_en && rd_addr == ADDR_SUPPLY_HIGH;
  endsequence

  chk_hv_event_set: assert property (@(posedge clk) disable iff (rst)
    hv_rise |=> hv_fault_event_q)
    else $error("supply fault event not latched");
  chk_hv_event_hold: assert property (@(posedge clk) disable iff (rst)
    hv_fault_event_q && !cor_read |=> hv_fault_event_q)
    else $error("supply fault event lost without read");
  chk_hv_hyst_low: assert property (@(posedge clk) disable iff (rst)
    !supply_bad_q && supply_sample < SUPPLY_FALL_CNT |=> supply_bad_q)
    else $error("supply did not go bad below 32 V");
  chk_hv_hyst_high: assert property (@(posedge clk) disable iff (rst)
    supply_bad_q && supply_sample > SUPPLY_RISE_CNT |=> !supply_bad_q)
    else $error("supply did not go good above 44 V");
  chk_hold_off: assert property (@(posedge clk) disable iff (rst)
    supply_bad_q && supply_sample <= SUPPLY_RISE_CNT |=> ports_hold_off_q)
    else $error("ports not held off");
  chk_tsd_set: assert property (@(posedge clk) disable iff (rst)
    tsd_rise |=> tsd_event_q && thermal_shutdown_q)
    else $error("thermal event not latched");
  chk_tsd_limit: assert property (@(posedge clk) disable iff (rst)
    ports_powered && tsd_enable && temp_sample > over_temp_th |=>
    thermal_shutdown_q)
    else $error("no shutdown above over-temperature limit");
  chk_tsd_safe: assert property (@(posedge clk) disable iff (rst)
    ports_powered && !tsd_enable && temp_sample > safe_temp_th |=>
    thermal_shutdown_q)
    else $error("no shutdown above safe limit");
  chk_tsd_clear: assert property (@(posedge clk) disable iff (rst)
    tsd_enable && temp_sample <= over_temp_th |=> !thermal_shutdown_q)
    else $error("shutdown held below over-temperature limit");
  chk_status_reserved: assert property (@(posedge clk) disable iff (rst)
    global_status_q[7] == 1'b0 && global_status_q[1] == 1'b0)
    else $error("reserved status bits set");
  chk_status_stable: assert property (@(posedge clk) disable iff (rst)
    strap_done_q |=> $stable(global_status_q))
    else $error("status changed after strap capture");
  chk_temp_read: assert property (@(posedge clk) disable iff (rst)
    rd_en && rd_addr == ADDR_DIE_TEMP |=> rd_data_q == $past(temp_sample))
    else $error("temperature read wrong");
  chk_high_frozen: assert property (@(posedge clk) disable iff (rst)
    s_low_read ##1 s_high_read |=>
    rd_data_q == $past(supply_sample[15:8], 2))
    else $error("high byte not frozen");
  chk_cor_clear: assert property (@(posedge clk) disable iff (rst)
    cor_read && !hv_rise && !tsd_rise |=> !hv_fault_event_q && !tsd_event_q)
    else $error("events not cleared by read");
endmodule : stsr_regs

// ### logic/stsr_pkg.sv
// Purpose: Constants for the supply and thermal status register bank.
// Assumes: Byte-wide register reads addressed by an 8-bit offset.
// Notes: Threshold codes are in supply measurement counts.
package stsr_pkg;
  // ********************************************************************
  // Register offsets
  // ********************************************************************
  localparam logic [7:0] ADDR_EVENT_COR = 8'h03;
  localparam logic [7:0] ADDR_GLOBAL_STATUS = 8'h05;
  localparam logic [7:0] ADDR_DIE_TEMP = 8'h06;
  localparam logic [7:0] ADDR_SUPPLY_LOW = 8'h07;
  localparam logic [7:0] ADDR_SUPPLY_HIGH = 8'h08;
  // ********************************************************************
  // Field positions and reset values
  // ********************************************************************
  localparam int HV_FAULT_BIT = 4;
  localparam int TSD_BIT = 3;
  localparam int ADDR_FIELD_LSB = 2;
  localparam int AUTO_BIT = 0;
  localparam logic [7:0] GLOBAL_STATUS_RST = 8'h00;
  localparam logic [7:0] EVENT_RST = 8'h00;
  // ********************************************************************
  // Supply thresholds: 32 V and 44 V at 5.835 mV per count
  // ********************************************************************
  localparam int SUPPLY_UV_PER_COUNT = 5835;
  localparam int SUPPLY_FALL_MV = 32000;
  localparam int SUPPLY_RISE_MV = 44000;
  localparam logic [15:0] SUPPLY_FALL_CNT =
    16'((SUPPLY_FALL_MV * 1000) / SUPPLY_UV_PER_COUNT);
  localparam logic [15:0] SUPPLY_RISE_CNT =
    16'((SUPPLY_RISE_MV * 1000) / SUPPLY_UV_PER_COUNT);
endpackage : stsr_pkg

// ### sim/stsr_host_model.sv
// Purpose: Host side model that issues single byte register reads.
// Assumes: Inputs of the bank change on the falling clock edge.
// Notes: Address is inverted once released so stale values never match.
`timescale 1ns/10ps
module stsr_host_model (
  input wire logic clk,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data_q
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 8'h00;
  end
  // Data is sampled a full cycle after the strobe, when it is settled.
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en = 1'b0;
    rd_addr = ~a;
    @(negedge clk);
    d = rd_data_q;
  endtask : read
  // Two reads on consecutive edges, as a host streams a word.
  task automatic read_pair(input logic [7:0] a0, input logic [7:0] a1,
                           output logic [7:0] d0, output logic [7:0] d1);
    @(negedge clk);
    rd_en = 1'b1;
    rd_addr = a0;
    @(negedge clk);
    d0 = rd_data_q;
    rd_addr = a1;
    @(negedge clk);
    d1 = rd_data_q;
    rd_en = 1'b0;
    rd_addr = ~a1;
  endtask : read_pair
endmodule : stsr_host_model

// ### sim/stsr_regs_tb_top.sv
// Purpose: Self-checking bench for the supply and thermal status bank.
// Assumes: Read data settles one cycle after the strobe edge.
// Notes: Inputs change on the falling edge of the clock.
`timescale 1ns/10ps
module stsr_regs_tb_top;
  import stsr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] supply = 16'h0000;
  logic [7:0] temp = 8'h00;
  logic tsd_en = 1'b1;
  logic powered = 1'b1;
  logic [4:0] pins = 5'h15;
  logic auto_strap = 1'b1;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic hold;
  logic tsd;
  int n_fail = 0;
  int compares = 0;
  always #50 clk = ~clk;
  stsr_host_model host (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data_q(rd_data));
  stsr_regs dut (.clk(clk), .rst(rst), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data_q(rd_data), .supply_sample(supply), .temp_sample(temp),
    .over_temp_th(8'h64), .safe_temp_th(8'h32), .tsd_enable(tsd_en),
    .ports_powered(powered), .addr_pins(pins), .auto_pin(auto_strap),
    .ports_hold_off_q(hold), .thermal_shutdown_q(tsd));
  // ********************************************************************
  // Shared tasks
  // ********************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read(a, d);
    check(d, exp);
  endtask : rd_chk
  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  // ********************************************************************
  // Scenarios
  // ********************************************************************
  task automatic t_reset();
    settle(5);
    check({7'h00, hold}, 8'h01);
    check({7'h00, tsd}, 8'h00);
    check(rd_data, 8'h00);
    settle(5);
    rst = 1'b0;
  endtask : t_reset
  task automatic t_status();
    settle(8);
    rd_chk(ADDR_GLOBAL_STATUS, 8'h55);
    pins = 5'h0a;
    auto_strap = 1'b0;
    settle(8);
    rd_chk(ADDR_GLOBAL_STATUS, 8'h55);
    rst = 1'b1;
    settle(3);
    check({7'h00, hold}, 8'h01);
    check(rd_data, 8'h00);
    rst = 1'b0;
    settle(8);
    rd_chk(ADDR_GLOBAL_STATUS, 8'h28);
  endtask : t_status
  task automatic t_supply();
    rd_chk(ADDR_EVENT_COR, 8'h00);
    supply = SUPPLY_RISE_CNT;
    settle(4);
    check({7'h00, hold}, 8'h01);
    supply = SUPPLY_RISE_CNT + 16'h0001;
    settle(4);
    check({7'h00, hold}, 8'h00);
    supply = SUPPLY_FALL_CNT;
    settle(4);
    check({7'h00, hold}, 8'h00);
    rd_chk(ADDR_EVENT_COR, 8'h00);
    supply = SUPPLY_FALL_CNT - 16'h0001;
    settle(4);
    check({7'h00, hold}, 8'h01);
    rd_chk(ADDR_EVENT_COR, 8'h10);
    rd_chk(ADDR_EVENT_COR, 8'h00);
    supply = 16'h1770;
    settle(4);
    check({7'h00, hold}, 8'h01);
    supply = 16'h2345;
    settle(4);
  endtask : t_supply
  task automatic t_thermal();
    temp = 8'h64;
    settle(4);
    check({7'h00, tsd}, 8'h00);
    temp = 8'h65;
    settle(4);
    check({7'h00, tsd}, 8'h01);
    rd_chk(ADDR_EVENT_COR, 8'h08);
    temp = 8'h64;
    settle(4);
    check({7'h00, tsd}, 8'h00);
    tsd_en = 1'b0;
    settle(4);
    check({7'h00, tsd}, 8'h01);
    rd_chk(ADDR_EVENT_COR, 8'h08);
    temp = 8'h28;
    settle(4);
    check({7'h00, tsd}, 8'h00);
    powered = 1'b0;
    temp = 8'h78;
    settle(4);
    check({7'h00, tsd}, 8'h00);
    rd_chk(ADDR_EVENT_COR, 8'h00);
  endtask : t_thermal
  task automatic t_meas();
    logic [7:0] lo;
    logic [7:0] hi;
    temp = 8'ha7;
    settle(2);
    rd_chk(ADDR_DIE_TEMP, 8'ha7);
    rd_chk(ADDR_SUPPLY_LOW, 8'h45);
    supply = 16'h3456;
    settle(2);
    rd_chk(ADDR_SUPPLY_HIGH, 8'h23);
    rd_chk(ADDR_SUPPLY_HIGH, 8'h34);
    rd_chk(8'h09, 8'h00);
    // The supply moves between the two reads, so only a frozen byte matches.
    supply = 16'h3456;
    fork
      host.read_pair(ADDR_SUPPLY_LOW, ADDR_SUPPLY_HIGH, lo, hi);
      begin
        repeat (2) @(negedge clk);
        supply = 16'h4567;
      end
    join
    check(lo, 8'h56);
    check(hi, 8'h34);
  endtask : t_meas
  // ********************************************************************
  // Sequence and watchdog
  // ********************************************************************
  // The whole run is under 150 cycles, so the limit is generous.
  initial begin
    #1000000;
    n_fail++;
    report_and_stop();
  end
  initial begin
    t_reset();
    t_status();
    t_supply();
    t_thermal();
    t_meas();
    report_and_stop();
  end
endmodule : stsr_regs_tb_top
